// >>> doga_pkg.sv
// Purpose: constants and types for the converter offset, gain and aux register bank
// Assumes: registers sit on a 32-bit classic wishbone bus, one word per index
// Notes: byte address of a register is four times its index
package doga_pkg;

    // register indices (byte address = index * 4)
    localparam logic [7:0] IDX_I_OFF_LO = 8'h3C;
    localparam logic [7:0] IDX_I_OFF_HI = 8'h3D;
    localparam logic [7:0] IDX_Q_OFF_LO = 8'h3E;
    localparam logic [7:0] IDX_Q_OFF_HI = 8'h3F;
    localparam logic [7:0] IDX_I_FS_LO = 8'h40;
    localparam logic [7:0] IDX_I_CTRL = 8'h41;
    localparam logic [7:0] IDX_I_AUX_LO = 8'h42;
    localparam logic [7:0] IDX_I_AUX_CTRL = 8'h43;
    localparam logic [7:0] IDX_Q_FS_LO = 8'h44;
    localparam logic [7:0] IDX_Q_CTRL = 8'h45;
    localparam logic [7:0] IDX_Q_AUX_LO = 8'h46;
    localparam logic [7:0] IDX_Q_AUX_CTRL = 8'h47;
    localparam logic [7:0] IDX_STATUS = 8'h50;
    localparam logic [7:0] IDX_FIRST = IDX_I_OFF_LO;
    localparam logic [7:0] IDX_LAST = IDX_Q_AUX_CTRL;
    localparam int NREG = 12;

    // field positions
    localparam int BIT_CONV_SLEEP = 7;
    localparam int BIT_AUX_SIGN = 7;
    localparam int BIT_AUX_SINK = 6;
    localparam int BIT_AUX_SLEEP = 5;
    localparam int BIT_ST_HEAD = 0;
    localparam int BIT_ST_FULL = 1;
    localparam int BIT_ST_READY = 2;

    // values after reset and writable-bit masks, slot 0 is index 0x3C
    localparam logic [7:0] RST_FS_LO = 8'hF9;
    localparam logic [7:0] RST_CONV_CTRL = 8'h01;
    localparam logic [7:0] MASK_CONV = 8'h83;
    localparam logic [7:0] MASK_AUX = 8'hE3;
    localparam logic [NREG-1:0][7:0] REG_RST = {
        8'h00, 8'h00, RST_CONV_CTRL, RST_FS_LO,
        8'h00, 8'h00, RST_CONV_CTRL, RST_FS_LO,
        8'h00, 8'h00, 8'h00, 8'h00};
    localparam logic [NREG-1:0][7:0] REG_MASK = {
        MASK_AUX, 8'hFF, MASK_CONV, 8'hFF,
        MASK_AUX, 8'hFF, MASK_CONV, 8'hFF,
        8'hFF, 8'hFF, 8'hFF, 8'hFF};
    localparam logic [9:0] FS_CODE_RST = {RST_CONV_CTRL[1:0], RST_FS_LO};

    // one sample pair on its way to the converters
    typedef struct packed {
        logic [15:0] i;
        logic [15:0] q;
    } doga_sample_t;

    // settings of one converter channel and its aux source
    typedef struct packed {
        logic [9:0] fullscale_code;
        logic conv_sleep;
        logic [9:0] aux_magnitude;
        logic aux_neg_leg;
        logic aux_sink;
        logic aux_sleep;
    } doga_chan_cfg_t;

    // whole state of the bank
    typedef struct packed {
        logic [NREG-1:0][7:0] regs;
        doga_sample_t [1:0] slot;
        logic [1:0] full;
        logic in_rdy;
        logic ack;
        logic [31:0] rdat;
    } doga_state_t;

endpackage

// >>> doga_regs.sv
// Purpose: offset, full-scale and aux current register bank with sample offset path
// Assumes: classic wishbone slave, synchronous active-high reset, 50 MHz clock
// Notes: samples get the channel offset added, then pass a two-entry buffer
//
// Contract
// - add in-phase offset to every in-phase sample
// - add quadrature offset to every quadrature sample
// - in-phase full-scale code 10 bits, default 1F9
// - full-scale code drives current linearly
// - quadrature full-scale code, same layout and mapping
// - in-phase control bit 7 sleeps converter
// - quadrature control bit 7 sleeps converter
// - in-phase aux magnitude is a 10-bit code
// - quadrature aux magnitude is a 10-bit code
// - in-phase aux sign picks output leg
// - in-phase aux direction picks source or sink
// - in-phase aux sleep bit, awake after reset
// - quadrature aux sign picks output leg
// - quadrature aux direction picks source or sink
`timescale 1ns/1ns
module doga_regs
    import doga_pkg::*;
(
    input wire logic clk_i, // 50 MHz clock
    input wire logic rst_i, // synchronous reset, high
    input wire logic wb_cyc_i, // bus cycle
    input wire logic wb_stb_i, // bus strobe
    input wire logic wb_we_i, // write enable
    input wire logic [31:0] wb_adr_i, // byte address
    input wire logic [3:0] wb_sel_i, // byte lanes
    input wire logic [31:0] wb_dat_i, // write data
    output logic [31:0] wb_dat_o, // read data
    output logic wb_ack_o, // acknowledge
    input wire logic s_valid_i, // sample offered
    input wire doga_sample_t s_data_i, // raw sample pair
    output logic s_ready_o, // buffer can take a sample
    output logic m_valid_o, // sample for converters valid
    output doga_sample_t m_data_o, // offset-corrected sample pair
    input wire logic m_ready_i, // converters take sample
    output doga_chan_cfg_t inphase_cfg_o, // in-phase channel settings
    output doga_chan_cfg_t quadrature_cfg_o // quadrature channel settings
);

    doga_state_t q;
    doga_state_t d;

    logic req;
    logic [7:0] idx;
    logic [3:0] rslot;
    logic in_map;
    logic wr_en;
    logic push;
    logic pop;
    doga_sample_t adj;
    logic [15:0] i_off;
    logic [15:0] q_off;

    // map a register index onto its storage slot
    function automatic logic [3:0] reg_slot(input logic [7:0] x);
        logic [7:0] diff;
        diff = x - IDX_FIRST;
        return diff[3:0];
    endfunction

    // wrap-around add; the converters expect plain modulo sums
    function automatic logic [15:0] add_off(input logic [15:0] s, input logic [15:0] o);
        logic [15:0] sum;
        sum = s + o;
        return sum;
    endfunction

    // gather one channel's settings from its four registers
    function automatic doga_chan_cfg_t make_cfg(
        input logic [7:0] fs_lo,
        input logic [7:0] ctrl,
        input logic [7:0] aux_lo,
        input logic [7:0] aux_ctrl
    );
        doga_chan_cfg_t c;
        c.fullscale_code = {ctrl[1:0], fs_lo};
        c.conv_sleep = ctrl[BIT_CONV_SLEEP];
        c.aux_magnitude = {aux_ctrl[1:0], aux_lo};
        c.aux_neg_leg = aux_ctrl[BIT_AUX_SIGN];
        c.aux_sink = aux_ctrl[BIT_AUX_SINK];
        c.aux_sleep = aux_ctrl[BIT_AUX_SLEEP];
        return c;
    endfunction

    // bus decode; upper address bits must be zero to hit the bank
    assign req = wb_cyc_i & wb_stb_i;
    assign idx = wb_adr_i[9:2];
    assign rslot = reg_slot(idx);
    assign in_map = (wb_adr_i[31:10] == 22'h0) && (idx >= IDX_FIRST) && (idx <= IDX_LAST);
    // a write lands at the edge where ack is seen, so the master's view holds
    assign wr_en = req & wb_we_i & q.ack & wb_sel_i[0] & in_map;

    // offsets straight from the registers, so a new value hits the next sample
    assign i_off = {q.regs[reg_slot(IDX_I_OFF_HI)], q.regs[reg_slot(IDX_I_OFF_LO)]};
    assign q_off = {q.regs[reg_slot(IDX_Q_OFF_HI)], q.regs[reg_slot(IDX_Q_OFF_LO)]};
    assign adj.i = add_off(s_data_i.i, i_off);
    assign adj.q = add_off(s_data_i.q, q_off);

    // buffer handshakes
    assign push = s_valid_i & q.in_rdy;
    assign pop = q.full[0] & m_ready_i;

    // next state of bus slave, register file and buffer
    always_comb begin
        d = q;
        // ack is a single-cycle pulse one cycle after the request
        d.ack = req & ~q.ack;
        d.rdat = 32'h0;
        if (in_map) begin
            d.rdat = {24'h0, q.regs[rslot]};
        end else if (idx == IDX_STATUS && wb_adr_i[31:10] == 22'h0) begin
            d.rdat[BIT_ST_HEAD] = q.full[0];
            d.rdat[BIT_ST_FULL] = q.full[1];
            d.rdat[BIT_ST_READY] = q.in_rdy;
        end
        // reserved bits are masked so they read back as zero
        if (wr_en) begin
            d.regs[rslot] = wb_dat_i[7:0] & REG_MASK[rslot];
        end
        // shift buffer: slot 0 is always the head, so outputs come from flops
        if (pop) begin
            d.slot[0] = q.slot[1];
            d.full = {1'b0, q.full[1]};
        end
        if (push) begin
            if (!d.full[0]) begin
                d.slot[0] = adj;
                d.full[0] = 1'b1;
            end else begin
                d.slot[1] = adj;
                d.full[1] = 1'b1;
            end
        end
        // ready only drops in reset or when both slots hold data, never losing a word
        d.in_rdy = ~d.full[1];
    end

    // state register
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            q.regs <= REG_RST;
            q.slot <= '0;
            q.full <= 2'h0;
            q.in_rdy <= 1'b0;
            q.ack <= 1'b0;
            q.rdat <= 32'h0;
        end else begin
            q <= d;
        end
    end

    // outputs straight from the state flops
    assign wb_dat_o = q.rdat;
    assign wb_ack_o = q.ack;
    assign s_ready_o = q.in_rdy;
    assign m_valid_o = q.full[0];
    assign m_data_o = q.slot[0];

    // channel settings feed the analog stage; code maps linearly to current
    assign inphase_cfg_o = make_cfg(
        q.regs[reg_slot(IDX_I_FS_LO)],
        q.regs[reg_slot(IDX_I_CTRL)],
        q.regs[reg_slot(IDX_I_AUX_LO)],
        q.regs[reg_slot(IDX_I_AUX_CTRL)]);
    assign quadrature_cfg_o = make_cfg(
        q.regs[reg_slot(IDX_Q_FS_LO)],
        q.regs[reg_slot(IDX_Q_CTRL)],
        q.regs[reg_slot(IDX_Q_AUX_LO)],
        q.regs[reg_slot(IDX_Q_AUX_CTRL)]);

    // checks on the bank's own behaviour
    default clocking cb @(posedge clk_i);
    endclocking
    default disable iff (rst_i);

    chk_ack_one_cycle: assert property (
        (req && !wb_ack_o) |=> wb_ack_o ##1 !wb_ack_o)
        else $error("ack not a one-cycle pulse after request");

    chk_i_offset_add: assert property (
        (push && !m_valid_o && !wr_en) |=>
        m_data_o.i == 16'($past(s_data_i.i) + $past(i_off)))
        else $error("in-phase offset not added");

    chk_q_offset_add: assert property (
        (push && !m_valid_o && !wr_en) |=>
        m_data_o.q == 16'($past(s_data_i.q) + $past(q_off)))
        else $error("quadrature offset not added");

    chk_i_fs_default: assert property (
        $past(rst_i) |-> inphase_cfg_o.fullscale_code == FS_CODE_RST)
        else $error("in-phase full-scale default wrong");

    chk_i_fs_write: assert property (
        (wr_en && idx == IDX_I_CTRL) |=>
        inphase_cfg_o.fullscale_code[9:8] == $past(wb_dat_i[1:0])
        && $stable(inphase_cfg_o.fullscale_code[7:0]))
        else $error("in-phase full-scale upper bits wrong");

    chk_q_fs_write: assert property (
        (wr_en && idx == IDX_Q_FS_LO) |=>
        quadrature_cfg_o.fullscale_code[7:0] == $past(wb_dat_i[7:0]))
        else $error("quadrature full-scale low byte wrong");

    chk_i_conv_sleep: assert property (
        (wr_en && idx == IDX_I_CTRL) |=>
        inphase_cfg_o.conv_sleep == $past(wb_dat_i[BIT_CONV_SLEEP]))
        else $error("in-phase sleep not applied");

    chk_q_conv_sleep: assert property (
        (wr_en && idx == IDX_Q_CTRL) |=>
        quadrature_cfg_o.conv_sleep == $past(wb_dat_i[BIT_CONV_SLEEP]))
        else $error("quadrature sleep not applied");

    chk_i_aux_mag: assert property (
        (wr_en && idx == IDX_I_AUX_LO) |=>
        inphase_cfg_o.aux_magnitude[7:0] == $past(wb_dat_i[7:0]))
        else $error("in-phase aux magnitude wrong");

    chk_q_aux_mag: assert property (
        (wr_en && idx == IDX_Q_AUX_LO) |=>
        quadrature_cfg_o.aux_magnitude[7:0] == $past(wb_dat_i[7:0]))
        else $error("quadrature aux magnitude wrong");

    chk_i_aux_sign: assert property (
        (wr_en && idx == IDX_I_AUX_CTRL) |=>
        inphase_cfg_o.aux_neg_leg == $past(wb_dat_i[BIT_AUX_SIGN]))
        else $error("in-phase aux sign wrong");

    chk_i_aux_dir: assert property (
        (wr_en && idx == IDX_I_AUX_CTRL) |=>
        inphase_cfg_o.aux_sink == $past(wb_dat_i[BIT_AUX_SINK]))
        else $error("in-phase aux direction wrong");

    chk_i_aux_sleep: assert property (
        $past(rst_i) |-> !inphase_cfg_o.aux_sleep)
        else $error("in-phase aux source asleep after reset");

    chk_q_aux_sign: assert property (
        (wr_en && idx == IDX_Q_AUX_CTRL) |=>
        quadrature_cfg_o.aux_neg_leg == $past(wb_dat_i[BIT_AUX_SIGN]))
        else $error("quadrature aux sign wrong");

    chk_q_aux_dir: assert property (
        (wr_en && idx == IDX_Q_AUX_CTRL) |=>
        quadrature_cfg_o.aux_sink == $past(wb_dat_i[BIT_AUX_SINK]))
        else $error("quadrature aux direction wrong");

    chk_cfg_hold: assert property (
        !wr_en |=> $stable(inphase_cfg_o) && $stable(quadrature_cfg_o))
        else $error("settings changed without a write");

    chk_stall_holds: assert property (
        (m_valid_o && !m_ready_i) |=> m_valid_o && $stable(m_data_o))
        else $error("stalled sample lost or changed");

    // register fields land whole; reserved bits never hold a one
    chk_q_fs_default: assert property (
        $past(rst_i) |-> quadrature_cfg_o.fullscale_code == FS_CODE_RST)
        else $error("quadrature full-scale default wrong");

    chk_conv_awake_rst: assert property (
        $past(rst_i) |-> !inphase_cfg_o.conv_sleep && !quadrature_cfg_o.conv_sleep)
        else $error("converter asleep after reset");

    chk_i_fs_low: assert property (
        (wr_en && idx == IDX_I_FS_LO) |=>
        inphase_cfg_o.fullscale_code[7:0] == $past(wb_dat_i[7:0]))
        else $error("in-phase full-scale low byte wrong");

    chk_q_fs_high: assert property (
        (wr_en && idx == IDX_Q_CTRL) |=>
        quadrature_cfg_o.fullscale_code[9:8] == $past(wb_dat_i[1:0]))
        else $error("quadrature full-scale upper bits wrong");

    chk_i_aux_high: assert property (
        (wr_en && idx == IDX_I_AUX_CTRL) |=>
        inphase_cfg_o.aux_magnitude[9:8] == $past(wb_dat_i[1:0]))
        else $error("in-phase aux magnitude upper bits wrong");

    chk_q_aux_high: assert property (
        (wr_en && idx == IDX_Q_AUX_CTRL) |=>
        quadrature_cfg_o.aux_magnitude[9:8] == $past(wb_dat_i[1:0]))
        else $error("quadrature aux magnitude upper bits wrong");

    chk_i_aux_wake: assert property (
        (wr_en && idx == IDX_I_AUX_CTRL) |=>
        inphase_cfg_o.aux_sleep == $past(wb_dat_i[BIT_AUX_SLEEP]))
        else $error("in-phase aux sleep not applied");

    chk_q_aux_wake: assert property (
        (wr_en && idx == IDX_Q_AUX_CTRL) |=>
        quadrature_cfg_o.aux_sleep == $past(wb_dat_i[BIT_AUX_SLEEP]))
        else $error("quadrature aux sleep not applied");

    chk_conv_reserved: assert property (
        ((q.regs[reg_slot(IDX_I_CTRL)] | q.regs[reg_slot(IDX_Q_CTRL)]) & ~MASK_CONV) == 8'h00)
        else $error("converter control reserved bit set");

    chk_aux_reserved: assert property (
        ((q.regs[reg_slot(IDX_I_AUX_CTRL)] | q.regs[reg_slot(IDX_Q_AUX_CTRL)]) & ~MASK_AUX) == 8'h00)
        else $error("aux control reserved bit set");

    // offset bytes reach the adders as soon as they are written
    chk_off_default: assert property (
        $past(rst_i) |-> i_off == 16'h0000 && q_off == 16'h0000)
        else $error("offsets not zero after reset");

    chk_i_off_low: assert property (
        (wr_en && idx == IDX_I_OFF_LO) |=>
        i_off[7:0] == $past(wb_dat_i[7:0]))
        else $error("in-phase offset low byte wrong");

    chk_i_off_high: assert property (
        (wr_en && idx == IDX_I_OFF_HI) |=>
        i_off[15:8] == $past(wb_dat_i[7:0]))
        else $error("in-phase offset high byte wrong");

    chk_q_off_low: assert property (
        (wr_en && idx == IDX_Q_OFF_LO) |=>
        q_off[7:0] == $past(wb_dat_i[7:0]))
        else $error("quadrature offset low byte wrong");

    chk_q_off_high: assert property (
        (wr_en && idx == IDX_Q_OFF_HI) |=>
        q_off[15:8] == $past(wb_dat_i[7:0]))
        else $error("quadrature offset high byte wrong");

    // bus answers: no stray ack, no write before ack, unmapped reads give zero
    chk_ack_idle: assert property (
        !req |=> !wb_ack_o)
        else $error("ack without a request");

    chk_write_waits_ack: assert property (
        (req && wb_we_i && !wb_ack_o) |=>
        $stable(inphase_cfg_o) && $stable(quadrature_cfg_o))
        else $error("write landed before ack");

    chk_unmapped_zero: assert property (
        (req && !wb_ack_o && !in_map && idx != IDX_STATUS) |=>
        wb_dat_o == 32'h0000_0000)
        else $error("unmapped read not zero");

    chk_status_full: assert property (
        (req && !wb_we_i && !wb_ack_o && idx == IDX_STATUS && wb_adr_i[31:10] == 22'h0) |=>
        wb_dat_o[BIT_ST_FULL] == $past(q.full[1]))
        else $error("status full bit wrong");

    // buffer: a full buffer refuses, a pop moves the tail word up
    chk_full_refuses: assert property (
        (q.full[1] && !pop) |=>
        !s_ready_o)
        else $error("full buffer still ready");

    chk_pop_advance: assert property (
        (pop && q.full[1]) |=>
        m_valid_o && m_data_o == $past(q.slot[1]))
        else $error("tail word not moved to head");

    chk_drain_empty: assert property (
        (pop && !q.full[1] && !push) |=>
        !m_valid_o)
        else $error("empty buffer still valid");

    chk_ready_after_pop: assert property (
        (pop && !push) |=> s_ready_o)
        else $error("ready not back after pop");

endmodule

// >>> tb_top.sv
// Purpose: self-checking bench for the offset, full-scale and aux register bank
// Assumes: ack one cycle after a request, registers at byte address index * 4
// Notes: table rows cover defaults, write masks and readback; hand tests follow
`timescale 1ns/1ns
module tb_top;
    import doga_pkg::*;
    `define CHK(nm, e, g) begin checks++; if ((g) !== (e)) begin fail_count++; \
        $display("MISMATCH %s exp %0h got %0h", nm, e, g); end end
    typedef struct {logic [7:0] idx; logic [7:0] dflt; logic [7:0] wd; logic [7:0] rd;} doga_row_t;
    logic clk_i = 1'b0;
    logic rst_i = 1'b1;
    logic wb_cyc_i = 1'b0;
    logic wb_stb_i = 1'b0;
    logic wb_we_i = 1'b0;
    logic [31:0] wb_adr_i = 32'h0;
    logic [31:0] wb_dat_i = 32'h0;
    logic [31:0] wb_dat_o;
    logic wb_ack_o;
    logic s_valid_i = 1'b0;
    doga_sample_t s_data_i = '0;
    logic s_ready_o;
    logic m_valid_o;
    doga_sample_t m_data_o;
    logic m_ready_i = 1'b0;
    doga_chan_cfg_t inphase_cfg_o;
    doga_chan_cfg_t quadrature_cfg_o;
    int fail_count = 0;
    int checks = 0;
    int cycles = 0;
    logic [31:0] rd;
    // reserved bits read back as zero, the last row is an unmapped index
    doga_row_t rows [13] = '{
        '{8'h3C, 8'h00, 8'hA5, 8'hA5}, '{8'h3D, 8'h00, 8'h12, 8'h12}, '{8'h3E, 8'h00, 8'h5A, 8'h5A},
        '{8'h3F, 8'h00, 8'h81, 8'h81}, '{8'h40, 8'hF9, 8'h34, 8'h34}, '{8'h41, 8'h01, 8'hFF, 8'h83},
        '{8'h42, 8'h00, 8'hCD, 8'hCD}, '{8'h43, 8'h00, 8'hFF, 8'hE3}, '{8'h44, 8'hF9, 8'h01, 8'h01},
        '{8'h45, 8'h01, 8'hFE, 8'h82}, '{8'h46, 8'h00, 8'h01, 8'h01}, '{8'h47, 8'h00, 8'hC2, 8'hC2},
        '{8'h48, 8'h00, 8'hFF, 8'h00}};

    doga_regs doga_regs_inst (
        .clk_i(clk_i), .rst_i(rst_i), .wb_cyc_i(wb_cyc_i), .wb_stb_i(wb_stb_i), .wb_we_i(wb_we_i),
        .wb_adr_i(wb_adr_i), .wb_sel_i(4'hF), .wb_dat_i(wb_dat_i), .wb_dat_o(wb_dat_o), .wb_ack_o(wb_ack_o),
        .s_valid_i(s_valid_i), .s_data_i(s_data_i), .s_ready_o(s_ready_o), .m_valid_o(m_valid_o),
        .m_data_o(m_data_o), .m_ready_i(m_ready_i), .inphase_cfg_o(inphase_cfg_o),
        .quadrature_cfg_o(quadrature_cfg_o));

    // 50 MHz clock
    always #10 clk_i = ~clk_i;

    // watchdog, the whole run needs well under a thousand cycles
    always @(posedge clk_i) begin
        cycles++;
        if (cycles == 5000) begin
            fail_count++;
            stop_test();
        end
    end

    task automatic stop_test();
        $display("checks %0d fail_count %0d", checks, fail_count);
        if (fail_count == 0 && checks > 0) begin
            $display("TB: PASS");
        end else begin
            $display("TB: FAIL");
        end
        $finish;
    endtask

    // classic single cycle, held until ack is sampled high
    task automatic wb(input logic we, input logic [31:0] adr, input logic [7:0] wd, output logic [31:0] q);
        @(posedge clk_i);
        wb_cyc_i <= 1'b1;
        wb_stb_i <= 1'b1;
        wb_we_i <= we;
        wb_adr_i <= adr;
        wb_dat_i <= {24'h0, wd};
        do @(posedge clk_i); while (wb_ack_o !== 1'b1);
        q = wb_dat_o;
        wb_cyc_i <= 1'b0;
        wb_stb_i <= 1'b0;
    endtask

    // offer one sample pair and hold it until taken
    task automatic send(input doga_sample_t d);
        @(posedge clk_i);
        s_valid_i <= 1'b1;
        s_data_i <= d;
        do @(posedge clk_i); while (s_ready_o !== 1'b1);
        s_valid_i <= 1'b0;
    endtask

    // take one sample pair from the head and compare it
    task automatic recv(input doga_sample_t e);
        @(posedge clk_i);
        m_ready_i <= 1'b1;
        do @(posedge clk_i); while (m_valid_o !== 1'b1);
        `CHK("m_data", e, m_data_o)
        m_ready_i <= 1'b0;
    endtask

    initial begin
        repeat (5) @(posedge clk_i);
        rst_i <= 1'b0;
        `CHK("cfg_i_rst", {10'h1F9, 14'h0}, inphase_cfg_o)
        `CHK("cfg_q_rst", {10'h1F9, 14'h0}, quadrature_cfg_o)
        foreach (rows[k]) begin
            wb(1'b0, {22'h0, rows[k].idx, 2'h0}, 8'h00, rd);
            `CHK("reg_default", {24'h0, rows[k].dflt}, rd)
        end
        foreach (rows[k]) begin
            wb(1'b1, {22'h0, rows[k].idx, 2'h0}, rows[k].wd, rd);
            wb(1'b0, {22'h0, rows[k].idx, 2'h0}, 8'h00, rd);
            `CHK("reg_readback", {24'h0, rows[k].rd}, rd)
        end
        // every field lands in its slot of the channel settings
        `CHK("cfg_i", {10'h334, 1'b1, 10'h3CD, 3'b111}, inphase_cfg_o)
        `CHK("cfg_q", {10'h201, 1'b1, 10'h201, 3'b110}, quadrature_cfg_o)
        // address above the decoded window aliases nothing
        wb(1'b1, 32'h0000_04F0, 8'h77, rd);
        wb(1'b0, 32'h0000_00F0, 8'h00, rd);
        `CHK("alias", 32'h0000_00A5, rd)
        // two words fill the buffer with the sink stalled, offsets wrap mod 2^16
        send('{i: 16'hFFFF, q: 16'h7EA6});
        send('{i: 16'h0001, q: 16'h0002});
        @(posedge clk_i);
        `CHK("s_ready_full", 1'b0, s_ready_o)
        wb(1'b0, {22'h0, IDX_STATUS, 2'h0}, 8'h00, rd);
        `CHK("status_full", 32'h0000_0003, rd)
        recv('{i: 16'h12A4, q: 16'h0000});
        recv('{i: 16'h12A6, q: 16'h815C});
        @(posedge clk_i);
        `CHK("m_valid_empty", 1'b0, m_valid_o)
        // a second reset in mid-run brings back the in-phase settings and the in-phase offset low byte default
        rst_i <= 1'b1;
        repeat (2) @(posedge clk_i);
        rst_i <= 1'b0;
        `CHK("cfg_i_rst2", {10'h1F9, 14'h0}, inphase_cfg_o)
        wb(1'b0, {22'h0, IDX_I_OFF_LO, 2'h0}, 8'h00, rd);
        `CHK("off_rst2", 32'h0, rd)
        stop_test();
    end
endmodule
